/* File: hdl/dsf_framer.sv */
// Purpose: Splits 18-bit output values into flagged bytes on an 8N1 line
// Assumes: Command answers offered as ASCII bytes on cmd port
// Notes:   Measurement values win over command bytes at value bounds
`timescale 1ns/10ps
// What this block does
// - Bit rate never above 4 MBaud; divisor clamped to its minimum.
// - Reset leaves the line at 921.6 kBaud.
// - Characters are 8 data bits, no parity, one stop bit.
// - Values go as binary bytes; commands travel as ASCII bytes.
// - Each value is an 18-bit word, measurement or error.
// - Low, middle, high bytes carry flags 00, 01, x0 and six bits.
// - Low byte first, then middle, then high.
// - High byte bit 7 cleared on a block's last value.
// - High byte bit 7 set on every other value.
// - First value always sent; further values follow in same format.
// - Overload replaces the value with an error code.
// - Value output continues while command traffic runs.
// - Selection query answered by returning the selection mask on sel_mask_o one cycle later.
module dsf_framer (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    // Configuration
    input  wire logic                       div_load_i,
    input  wire logic [dsf_pkg::DIV_W-1:0]  div_i,
    // Output values
    input  wire logic                       val_valid_i,
    input  wire dsf_pkg::dsf_value_t        val_i,
    output logic                            val_ready_o,
    output logic                            overload_o,
    // Command answer bytes
    input  wire logic                       cmd_valid_i,
    input  wire logic [7:0]                 cmd_data_i,
    output logic                            cmd_ready_o,
    // Selection query answer
    input  wire logic                       query_output_selection_command_i,
    input  wire logic [7:0]                 sel_mask_i,
    output logic                            sel_valid_o,
    output logic [7:0]                      sel_mask_o,
    // Serial line
    output logic                            txd_o
);
    import dsf_pkg::*;

    // Bytes of the current value
    function automatic logic [7:0] dsf_byte(input logic [VAL_W-1:0] d,
                                            input dsf_byte_t which,
                                            input logic last);
        logic [7:0] b;
        b = 8'h00;
        case (which)
            DSF_LO:  b = {FLAG_LO,  d[LO_LSB  +: PAY_W]};
            DSF_MID: b = {FLAG_MID, d[MID_LSB +: PAY_W]};
            DSF_HI:  b = {(last ? HI_LAST : HI_MORE), HI_B6,
                          d[HI_LSB +: PAY_W]};
            default: b = 8'h00;
        endcase
        return b;
    endfunction : dsf_byte

    ////////////////////////////////////////////////////////////////////
    // Divisor register
    logic [DIV_W-1:0] div_r, div_nxt;

    always_comb begin
        div_nxt = div_r;
        if (div_load_i) begin
            div_nxt = (div_i < DIV_MIN) ? DIV_MIN : div_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_r <= DIV_DEFAULT;
        end else begin
            div_r <= div_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Byte sequencer
    typedef enum logic [1:0] {
        DSF_IDLE,
        DSF_VAL,
        DSF_CMD
    } dsf_state_t;

    dsf_state_t       st_r,    st_nxt;
    dsf_byte_t        idx_r,   idx_nxt;
    logic [VAL_W-1:0] data_r,  data_nxt;
    logic             last_r,  last_nxt;
    logic [7:0]       cmdb_r,  cmdb_nxt;
    logic             vrdy_r,  vrdy_nxt;
    logic             crdy_r,  crdy_nxt;
    logic             ovl_r,   ovl_nxt;
    logic             pend_r,  pend_nxt;
    logic             plast_r, plast_nxt;
    logic             tx_ready;
    logic             tx_valid;
    logic [7:0]       tx_data;

    always_comb begin
        st_nxt   = st_r;
        idx_nxt  = idx_r;
        data_nxt = data_r;
        last_nxt = last_r;
        cmdb_nxt = cmdb_r;
        vrdy_nxt = 1'h0;
        crdy_nxt = 1'h0;
        ovl_nxt  = 1'h0;
        pend_nxt  = pend_r;
        plast_nxt = plast_r;
        tx_valid = 1'h0;
        tx_data  = 8'h00;
        case (st_r)
            DSF_IDLE: begin
                if (val_valid_i && !vrdy_r) begin
                    // Take a binary value
                    data_nxt = val_i.data;
                    last_nxt = val_i.last;
                    idx_nxt  = DSF_LO;
                    vrdy_nxt = 1'h1;
                    st_nxt   = DSF_VAL;
                end else if (cmd_valid_i && !crdy_r) begin
                    // ASCII answer byte between values
                    cmdb_nxt = cmd_data_i;
                    crdy_nxt = 1'h1;
                    st_nxt   = DSF_CMD;
                end
            end
            DSF_VAL: begin
                tx_valid = 1'h1;
                tx_data  = dsf_byte(data_r, idx_r, last_r);
                // A value arriving mid-send is overload; the word on the
                // line finishes intact so the receiver never sees a torn word
                if (val_valid_i && !vrdy_r) begin
                    pend_nxt  = 1'h1;
                    plast_nxt = plast_r | val_i.last;
                    vrdy_nxt  = 1'h1;
                    ovl_nxt   = 1'h1;
                end
                if (tx_ready) begin
                    case (idx_r)
                        DSF_LO:  idx_nxt = DSF_MID;
                        DSF_MID: idx_nxt = DSF_HI;
                        default: begin
                            if (pend_nxt) begin
                                // Error word in place of the refused value
                                data_nxt  = ERR_OVERLOAD;
                                last_nxt  = plast_nxt;
                                idx_nxt   = DSF_LO;
                                pend_nxt  = 1'h0;
                                plast_nxt = 1'h0;
                            end else begin
                                st_nxt = DSF_IDLE;
                            end
                        end
                    endcase
                end
            end
            DSF_CMD: begin
                tx_valid = 1'h1;
                tx_data  = cmdb_r;
                if (tx_ready) begin
                    st_nxt = DSF_IDLE;
                end
            end
            default: st_nxt = DSF_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r   <= DSF_IDLE;
            idx_r  <= DSF_LO;
            data_r <= '0;
            last_r <= 1'h0;
            cmdb_r <= 8'h00;
            vrdy_r <= 1'h0;
            crdy_r <= 1'h0;
            ovl_r  <= 1'h0;
            pend_r  <= 1'h0;
            plast_r <= 1'h0;
        end else begin
            st_r   <= st_nxt;
            idx_r  <= idx_nxt;
            data_r <= data_nxt;
            last_r <= last_nxt;
            cmdb_r <= cmdb_nxt;
            vrdy_r <= vrdy_nxt;
            crdy_r <= crdy_nxt;
            ovl_r  <= ovl_nxt;
            pend_r  <= pend_nxt;
            plast_r <= plast_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Selection query answer
    logic       selv_r, selv_nxt;
    logic [7:0] selm_r, selm_nxt;

    always_comb begin
        selv_nxt = query_output_selection_command_i;
        selm_nxt = query_output_selection_command_i ? sel_mask_i : selm_r;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            selv_r <= 1'h0;
            selm_r <= 8'h00;
        end else begin
            selv_r <= selv_nxt;
            selm_r <= selm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Character transmitter
    dsf_uart_tx u_tx (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .div_i     (div_r),
        .valid_i   (tx_valid),
        .data_i    (tx_data),
        .ready_o   (tx_ready),
        .txd_o     (txd_o)
    );

    assign val_ready_o = vrdy_r;
    assign cmd_ready_o = crdy_r;
    assign overload_o  = ovl_r;
    assign sel_valid_o = selv_r;
    assign sel_mask_o  = selm_r;
endmodule : dsf_framer

/* File: hdl/dsf_pkg.sv */
// Purpose: Shared constants and types for the displacement serial framer
// Assumes: 125 MHz system clock
// Notes:   Divisor values are bit periods in clock cycles
package dsf_pkg;
    // Clock and line rates
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned MAX_BAUD        = 4_000_000;
    localparam int unsigned DEFAULT_BAUD    = 921_600;
    localparam int          DIV_W           = 16;
    // Shortest legal bit period rounds up
    localparam logic [DIV_W-1:0] DIV_MIN     = DIV_W'((CLK_HZ + MAX_BAUD - 1) / MAX_BAUD);
    localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / DEFAULT_BAUD);
    // Character framing
    localparam int          DATA_BITS       = 8;
    localparam int          FRAME_BITS      = 10;
    localparam int          BITCNT_W        = 4;
    // Value layout
    localparam int          VAL_W           = 18;
    localparam int          PAY_W           = 6;
    localparam int          LO_LSB          = 0;
    localparam int          MID_LSB         = 6;
    localparam int          HI_LSB          = 12;
    localparam logic [1:0]  FLAG_LO         = 2'h0;
    localparam logic [1:0]  FLAG_MID        = 2'h1;
    localparam logic        HI_MORE         = 1'h1;
    localparam logic        HI_LAST         = 1'h0;
    localparam logic        HI_B6           = 1'h0;
    // Substituted when output is overloaded
    localparam logic [VAL_W-1:0] ERR_OVERLOAD = 18'h3FFFF;

    // One output value offered to the framer
    typedef struct packed {
        logic [VAL_W-1:0] data;
        logic             last;
    } dsf_value_t;

    typedef enum logic [1:0] {
        DSF_LO,
        DSF_MID,
        DSF_HI
    } dsf_byte_t;
endpackage : dsf_pkg

/* File: hdl/dsf_uart_tx.sv */
// Purpose: 8N1 serial character transmitter
// Assumes: Divisor stable while a character is sent
// Notes:   Ready only after the stop bit has finished
`timescale 1ns/10ps
module dsf_uart_tx (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    // Configuration
    input  wire logic [dsf_pkg::DIV_W-1:0]  div_i,
    // Character in
    input  wire logic                       valid_i,
    input  wire logic [7:0]                 data_i,
    output logic                            ready_o,
    // Line
    output logic                            txd_o
);
    import dsf_pkg::*;

    logic [FRAME_BITS-1:0] shift_r,  shift_nxt;
    logic [BITCNT_W-1:0]   bits_r,   bits_nxt;
    logic [DIV_W-1:0]      cnt_r,    cnt_nxt;
    logic                  busy_r,   busy_nxt;
    logic                  txd_r,    txd_nxt;

    ////////////////////////////////////////////////////////////////////
    // Next state of the shifter
    always_comb begin
        shift_nxt = shift_r;
        bits_nxt  = bits_r;
        cnt_nxt   = cnt_r;
        busy_nxt  = busy_r;
        txd_nxt   = txd_r;
        if (!busy_r) begin
            txd_nxt = 1'h1;
            if (valid_i) begin
                // Stop, data LSB first, start; no parity
                shift_nxt = {1'h1, data_i, 1'h0};
                bits_nxt  = BITCNT_W'(FRAME_BITS);
                // Start bit on the line after the second edge, no idle period lost
                cnt_nxt   = DIV_W'(1);
                busy_nxt  = 1'h1;
            end
        end else if (cnt_r == DIV_W'(0) || cnt_r == DIV_W'(1)) begin
            // Bit period from the clock divisor
            if (bits_r == BITCNT_W'(0)) begin
                busy_nxt = 1'h0; // Stop bit done
            end else begin
                txd_nxt   = shift_r[0];
                shift_nxt = {1'h1, shift_r[FRAME_BITS-1:1]};
                bits_nxt  = bits_r - BITCNT_W'(1);
                cnt_nxt   = div_i;
            end
        end else begin
            cnt_nxt = cnt_r - DIV_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            shift_r <= '1;
            bits_r  <= '0;
            cnt_r   <= '0;
            busy_r  <= 1'h0;
            txd_r   <= 1'h1;
        end else begin
            shift_r <= shift_nxt;
            bits_r  <= bits_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= busy_nxt;
            txd_r   <= txd_nxt;
        end
    end

    assign ready_o = ~busy_r;
    assign txd_o   = txd_r;
endmodule : dsf_uart_tx

/* File: tb/dsf_framer_chk.sv */
// Purpose: Port checks for the framer
// Assumes: One clock domain
// Notes:   Bound into every dsf_framer
`timescale 1ns/10ps
module dsf_framer_chk (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    // Watched ports
    input wire logic       val_valid_i,
    input wire logic       val_ready_o,
    input wire logic       overload_o,
    input wire logic       cmd_ready_o,
    input wire logic       query_output_selection_command_i,
    input wire logic [7:0] sel_mask_i,
    input wire logic       sel_valid_o,
    input wire logic [7:0] sel_mask_o,
    input wire logic       txd_o
);
    import dsf_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the line last changed, saturating
    logic        txd_q_r;
    logic [15:0] run_r;
    logic [15:0] run_nxt;
    always_comb begin
        run_nxt = (run_r == 16'hFFFF) ? run_r : run_r + 16'h1;
        if (sys_rst_i) run_nxt = 16'hFFFF;
        else if (txd_o != txd_q_r) run_nxt = 16'h0;
    end
    always_ff @(posedge clk_i) begin
        txd_q_r <= txd_o;
        run_r   <= run_nxt;
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_rst_idle;
        disable iff (1'b0) sys_rst_i |=> txd_o && !val_ready_o && sel_mask_o == 8'h00;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("line not idle after reset");
    property p_ready_pulse; val_ready_o |=> !val_ready_o; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_start; val_ready_o && !overload_o |-> ##[0:2] !txd_o; endproperty
    a_start: assert property (p_start) else $error("no start bit");
    property p_bit_len; txd_o != txd_q_r |-> run_r >= DIV_MIN - 16'h1; endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit too short");
    property p_ovl; overload_o |-> val_ready_o; endproperty
    a_ovl: assert property (p_ovl) else $error("overload without take");
    property p_cmd; cmd_ready_o |-> !val_ready_o && !$past(val_valid_i); endproperty
    a_cmd: assert property (p_cmd) else $error("command beat a value");
    property p_sel;
        query_output_selection_command_i |=> sel_valid_o && sel_mask_o == $past(sel_mask_i);
    endproperty
    a_sel: assert property (p_sel) else $error("selection answer wrong");
    property p_sel_hold; !sel_valid_o |-> $stable(sel_mask_o); endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("selection changed");
    c_ovl: cover property (overload_o);
    c_cmd: cover property (cmd_ready_o);
    c_sel: cover property (sel_valid_o);
endmodule : dsf_framer_chk

bind dsf_framer dsf_framer_chk i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .val_valid_i(val_valid_i), .val_ready_o(val_ready_o), .overload_o(overload_o),
    .cmd_ready_o(cmd_ready_o), .sel_mask_i(sel_mask_i), .sel_valid_o(sel_valid_o),
    .query_output_selection_command_i(query_output_selection_command_i),
    .sel_mask_o(sel_mask_o), .txd_o(txd_o));

/* File: tb/dsf_framer_tb.sv */
// Purpose: Self-checking bench for the framer
// Assumes: Receiver model decodes the line
// Notes:   Random values from a fixed seed
`timescale 1ns/10ps
module dsf_framer_tb;
    import dsf_pkg::*;
    logic clk_i, sys_rst_i, div_load_i, val_valid_i, val_ready_o, overload_o;
    logic cmd_valid_i, cmd_ready_o, query_output_selection_command_i, sel_valid_o, txd_o;
    logic [15:0] div_i;
    logic [7:0]  cmd_data_i, sel_mask_i, sel_mask_o;
    logic [17:0] d;
    dsf_value_t  val_i;
    int          rx_div, seed, failures, n_compared, cyc, n;
    logic        ovl_seen;
    dsf_framer i_dut (.clk_i, .sys_rst_i, .div_load_i, .div_i, .val_valid_i, .val_i,
        .val_ready_o, .overload_o, .cmd_valid_i, .cmd_data_i, .cmd_ready_o,
        .query_output_selection_command_i, .sel_mask_i, .sel_valid_o, .sel_mask_o, .txd_o);
    dsf_rx_model i_rx (.clk_i(clk_i), .rxd_i(txd_o), .div_i(rx_div));
    ////////////////////////////////////////////////////////////////////////////////
    // Expected byte k of a value
    function automatic logic [7:0] byte_of(input logic [17:0] v, input logic l, input int k);
        if (k == 0) return {FLAG_LO, v[5:0]};
        if (k == 1) return {FLAG_MID, v[11:6]};
        return {~l, HI_B6, v[17:12]};
    endfunction : byte_of
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic check_word(input logic [17:0] v, input logic l);
        dsf_value_t w;
        w = i_rx.fifo.size() ? i_rx.fifo.pop_front() : 'x;
        n_compared++;
        if (w !== dsf_value_t'({v, l})) begin
            failures++;
            $display("CHECK FAILED word expected %h seen %h", {v, l}, w);
        end
    endtask : check_word
    task automatic send_val(input logic [17:0] v, input logic l);
        val_i <= '{data: v, last: l};
        val_valid_i <= 1'b1;
        do @(posedge clk_i); while (val_ready_o !== 1'b1);
        val_valid_i <= 1'b0;
        if (overload_o === 1'b1) ovl_seen = 1'b1;
    endtask : send_val
    task automatic meas_low(output int w);
        w = 0;
        while (txd_o !== 1'b0) @(posedge clk_i);
        while (txd_o === 1'b0) begin w++; @(posedge clk_i); end
    endtask : meas_low
    task automatic wait_idle();
        for (int h = 0; h < 12 * rx_div; h++) begin
            @(posedge clk_i);
            if (txd_o !== 1'b1) h = 0;
        end
    endtask : wait_idle
    task automatic end_of_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang limit
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {div_load_i, val_valid_i, cmd_valid_i, query_output_selection_command_i} = '0;
        {div_i, cmd_data_i, sel_mask_i, cyc, failures, n_compared} = '0;
        val_i = '0;
        sys_rst_i = 1'b1;
        rx_div = CLK_HZ / DEFAULT_BAUD;
        seed = 32'he6fff331;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        send_val(18'h2AAAB, 1'b1);
        meas_low(n);
        check("default bit", rx_div, n);
        wait_idle();
        check_word(18'h2AAAB, 1'b1);
        $display("test default_rate done");
        div_i <= 16'h000A;
        div_load_i <= 1'b1;
        @(posedge clk_i);
        div_load_i <= 1'b0;
        rx_div = (CLK_HZ + MAX_BAUD - 1) / MAX_BAUD;
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 18'h00001 : (i == 5) ? 18'h3FFFE : 18'($random(seed));
            send_val(d, i == 5);
            if (i == 0) meas_low(n);
            if (i == 0) check("clamped bit", rx_div, n);
            wait_idle();
            check_word(d, i == 5);
        end
        $display("test block done");
        ovl_seen = 1'b0;
        send_val(18'h12345, 1'b1);
        @(posedge clk_i);
        send_val(18'h0F0F0, 1'b1);
        check("overload", 1, 32'(ovl_seen));
        wait_idle();
        check_word(18'h12345, 1'b1);
        check_word(ERR_OVERLOAD, 1'b1);
        $display("test overload done");
        i_rx.fifo.delete();
        i_rx.bytes.delete();
        cmd_data_i <= 8'h41;
        cmd_valid_i <= 1'b1;
        send_val(18'h1C3A5, 1'b0);
        while (cmd_ready_o !== 1'b1) @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        wait_idle();
        for (int k = 0; k < 3; k++) begin
            check("byte", 32'(byte_of(18'h1C3A5, 1'b0, k)), 32'(i_rx.bytes[k]));
        end
        check("ascii", 32'h41, 32'(i_rx.bytes[3]));
        check_word(18'h1C3A5, 1'b0);
        $display("test command done");
        for (int k = 0; k < 4; k++) begin
            d = 18'($random(seed));
            sel_mask_i <= d[7:0];
            query_output_selection_command_i <= 1'b1;
            @(posedge clk_i);
            query_output_selection_command_i <= 1'b0;
            @(posedge clk_i);
            check("sel valid", 1, 32'(sel_valid_o));
            check("sel mask", 32'(d[7:0]), 32'(sel_mask_o));
        end
        check("framing", 0, i_rx.frame_errs);
        $display("test query done");
        end_of_test();
    end
endmodule : dsf_framer_tb

/* File: tb/dsf_rx_model.sv */
// Purpose: Serial receiver that rebuilds flagged values
// Assumes: Bit period given in clock cycles
// Notes:   Bytes and words kept in queues
`timescale 1ns/10ps
module dsf_rx_model (
    // Clock
    input wire logic clk_i,
    // Line and bit period
    input wire logic rxd_i,
    input var  int   div_i
);
    import dsf_pkg::*;
    logic [7:0]  bytes[$];
    dsf_value_t  fifo[$];
    int          frame_errs;
    int          stage;
    logic [11:0] part;
    logic [7:0]  b;
    ////////////////////////////////////////////////////////////////////////////////
    // Mid-bit sampling of each 8N1 character
    initial begin
        frame_errs = 0;
        stage = 0;
        forever begin
            do @(posedge clk_i); while (rxd_i !== 1'b0);
            repeat (div_i / 2) @(posedge clk_i);
            if (rxd_i !== 1'b0) frame_errs++;
            for (int i = 0; i < 8; i++) begin
                repeat (div_i) @(posedge clk_i);
                b[i] = rxd_i;
            end
            repeat (div_i) @(posedge clk_i);
            if (rxd_i !== 1'b1) frame_errs++;
            bytes.push_back(b);
            // High byte known by position, low and middle by flags
            if (stage == 2) begin
                if (b[6] !== HI_B6) frame_errs++;
                fifo.push_back('{data: {b[5:0], part}, last: ~b[7]});
                stage = 0;
            end else if (b[7:6] == FLAG_LO) begin
                part[5:0] = b[5:0];
                stage = 1;
            end else if (b[7:6] == FLAG_MID && stage == 1) begin
                part[11:6] = b[5:0];
                stage = 2;
            end else stage = 0;
        end
    end
endmodule : dsf_rx_model
